// [core/lofc_top.sv]
// file: lead-off detection control register bank with axi4-lite access
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Summary of operation
// R01: lead_off_control is a 24-bit read/write register at index 0x02 that resets to zero.
// R02: bit 0 is the master enable; clear turns all detection off, set runs the selected mode.
// R03: with the master enable clear the ac/dc select bit has no effect on the dc and ac detect enables.
// R04: enabled with select clear gives dc detection, with per-electrode ac still possible.
// R05: enabled with select set turns dc off and ac on for all but the common electrode.
// R06: left arm, left leg and right arm ac enables are the global select OR their own bit.
// R07: the common electrode ac enable comes only from its own bit 12.
// R08: an enabled calibration dac forces all ac detection off.
// R09: bits 23, 22, 21 and 18 pick in-phase or inverted excitation for la, ll, ra and ce.
// R10: bits 8:7 pick the ac excitation current from 12.5 to 100 nA rms.
// R11: bits 4:2 pick the dc current in 10 nA steps and act only while select is clear.
// R12: software writes zero into the reserved bit ranges.
// R13: the software reset bit returns this register to its reset value.
// R14: powering down through the power enable bit keeps the register contents.
// R15: decoded steering outputs are registered and change only on a write or a reset.
module lofc_top
    import lofc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [LOFC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [LOFC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output lofc_drive_t excitation,
    output logic analog_power_enable,
    output logic cal_dac_enable
);

    // ========================================================
    // bus front end
    logic wr_fire;
    lofc_wr_req_t wr_req;
    logic wr_err;
    logic [LOFC_IDX_W-1:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_err;

    lofc_axil_slave u_slave (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_fire(wr_fire),
        .wr_req(wr_req),
        .wr_err(wr_err),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // ========================================================
    // register state
    lofc_ctrl_t lo_q;
    lofc_ctrl_t lo_d;
    logic pwr_q;
    logic pwr_d;
    logic cal_q;
    logic cal_d;
    lofc_drive_t drive_q;
    lofc_drive_t drive_d;

    // ========================================================
    // write decode
    wire wr_gen = wr_fire & (wr_req.idx == LOFC_IDX_GEN_CTRL);
    wire wr_lo = wr_fire & (wr_req.idx == LOFC_IDX_LEAD_OFF);
    wire wr_map_hit = (wr_req.idx == LOFC_IDX_GEN_CTRL) | (wr_req.idx == LOFC_IDX_LEAD_OFF);
    // status is read only, so a write there is refused as well
    assign wr_err = ~wr_map_hit;

    // software reset is taken only from a write that enables byte 0
    wire gen_lane0 = wr_req.strb[0];
    wire software_reset_bit = wr_gen & gen_lane0 & wr_req.data[LOFC_GEN_SOFTWARE_RESET_BIT];

    // byte-lane merge of the 24-bit register
    logic [LOFC_REG_W-1:0] lo_merged;
    genvar g;
    generate
        for (g = 0; g < LOFC_REG_W / 8; g++) begin : g_lane
            assign lo_merged[g*8 +: 8] = wr_req.strb[g] ? wr_req.data[g*8 +: 8] : lo_q[g*8 +: 8];
        end
    endgenerate

    // reserved bits are not stored; they read back as zero
    wire [LOFC_REG_W-1:0] lo_written = lo_merged & LOFC_LEAD_OFF_RW;

    // next values: software reset overrides any write in the same cycle
    assign lo_d = software_reset_bit ? lofc_ctrl_t'(LOFC_LEAD_OFF_RST) :
                  wr_lo ? lofc_ctrl_t'(lo_written) : lo_q; // [R01] [R13]
    // power down only gates analog; the register above is left alone
    assign pwr_d = software_reset_bit ? 1'b0 :
                   (wr_gen & gen_lane0) ? wr_req.data[LOFC_GEN_PWR] : pwr_q; // [R14]
    assign cal_d = software_reset_bit ? 1'b0 :
                   (wr_gen & gen_lane0) ? wr_req.data[LOFC_GEN_CAL] : cal_q;

    // decode from next values so outputs land with the register
    lofc_decode u_decode (
        .ctrl(lo_d),
        .cal_dac_on(cal_d),
        .drive(drive_d)
    );

    // ========================================================
    // state update, frozen while clock enable is low
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lo_q <= lofc_ctrl_t'(LOFC_LEAD_OFF_RST); // [R01]
            pwr_q <= 1'b0;
            cal_q <= 1'b0;
        end else if (clk_en) begin
            lo_q <= lo_d;
            pwr_q <= pwr_d;
            cal_q <= cal_d;
        end
    end

    // steering outputs move only on a write or a reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            drive_q <= '0;
        end else if (clk_en & wr_fire) begin
            drive_q <= drive_d; // [R15]
        end
    end

    assign excitation = drive_q;
    assign analog_power_enable = pwr_q;
    assign cal_dac_enable = cal_q;

    // ========================================================
    // read mux; software_reset_bit bit always reads zero since it self-clears
    wire rd_gen = rd_idx == LOFC_IDX_GEN_CTRL;
    wire rd_lo = rd_idx == LOFC_IDX_LEAD_OFF;
    wire rd_stat = rd_idx == LOFC_IDX_STATUS;
    wire [31:0] gen_word = {29'h0000_0000, cal_q, pwr_q, 1'b0};
    wire [31:0] lo_word = {8'h00, lo_q};
    wire [31:0] stat_word = {17'h0_0000, pwr_q, drive_q};

    assign rd_data = rd_gen ? gen_word :
                     rd_lo ? lo_word :
                     rd_stat ? stat_word : 32'h0000_0000;
    assign rd_err = ~(rd_gen | rd_lo | rd_stat);

    // ========================================================
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // helper: write of the general register that asks for a reset
    sequence s_software_reset_bit_write;
        clk_en && software_reset_bit;
    endsequence

    // helper: plain general write, without software reset, that clears power
    sequence s_power_down_write;
        clk_en && wr_gen && gen_lane0 && !software_reset_bit && !wr_req.data[LOFC_GEN_PWR];
    endsequence

    chk_read_lead_off: assert property ( // [R01]
        rd_lo |-> (rd_data == {8'h00, lo_q}) && !rd_err)
        else $error("lead-off register read value wrong");

    chk_master_off: assert property ( // [R02]
        !lo_q.detection_master_enable && $past(clk_en && wr_fire)
        |-> !excitation.dc_detect_en && (excitation.ac_detect_en == 4'h0))
        else $error("detection active with master enable clear");

    chk_select_dont_care: assert property ( // [R03]
        (!lo_q.detection_master_enable && $past(!lo_q.detection_master_enable)
         && $changed(lo_q.global_ac_mode_select))
        |-> $stable(excitation.dc_detect_en) && $stable(excitation.ac_detect_en))
        else $error("select changed detection while master off");

    chk_dc_mode: assert property ( // [R04]
        (clk_en && wr_lo && lo_d.detection_master_enable && !lo_d.global_ac_mode_select)
        |=> excitation.dc_detect_en
            && (excitation.ac_detect_en[3] == (lo_q.left_arm_ac_enable && !cal_q)))
        else $error("dc mode decode wrong");

    chk_ac_mode: assert property ( // [R05]
        (clk_en && wr_fire && lo_d.detection_master_enable
         && lo_d.global_ac_mode_select && !cal_d)
        |=> !excitation.dc_detect_en && (excitation.ac_detect_en[3:1] == 3'b111))
        else $error("ac mode decode wrong");

    chk_ac_or_enable: assert property ( // [R06]
        $past(clk_en && wr_fire) && lo_q.detection_master_enable && !cal_q
        |-> excitation.ac_detect_en[2] == (lo_q.global_ac_mode_select || lo_q.left_leg_ac_enable)
            && excitation.ac_detect_en[1] == (lo_q.global_ac_mode_select || lo_q.right_arm_ac_enable))
        else $error("ac enable is not the or of select and own bit");

    chk_common_own_bit: assert property ( // [R07]
        $past(clk_en && wr_fire)
        |-> excitation.ac_detect_en[0]
            == (lo_q.detection_master_enable && !cal_q && lo_q.common_electrode_ac_enable))
        else $error("common electrode ac enable wrong");

    chk_cal_forces_off: assert property ( // [R08]
        cal_q && $past(clk_en && wr_fire) |-> excitation.ac_detect_en == 4'h0)
        else $error("ac detection on while cal dac enabled");

    chk_phase_map: assert property ( // [R09]
        clk_en && wr_lo |=> excitation.ac_phase
            == {lo_q.left_arm_ac_phase, lo_q.left_leg_ac_phase,
                lo_q.right_arm_ac_phase, lo_q.common_electrode_ac_phase})
        else $error("ac phase mapping wrong");

    chk_ac_level: assert property ( // [R10]
        clk_en && wr_lo |=> excitation.ac_excitation_level == $past(lo_written[8:7]))
        else $error("ac excitation level wrong");

    chk_dc_level: assert property ( // [R11]
        clk_en && wr_lo && !software_reset_bit ##1 lo_q.global_ac_mode_select
        |-> excitation.dc_excitation_level == 3'h0)
        else $error("dc level active in ac mode");

    chk_software_reset_bit_clears: assert property ( // [R13]
        s_software_reset_bit_write |=> (lo_q == lofc_ctrl_t'(LOFC_LEAD_OFF_RST)) && !pwr_q && !cal_q)
        else $error("software reset did not clear registers");

    chk_power_keeps: assert property ( // [R14]
        s_power_down_write |=> !pwr_q && $stable(lo_q))
        else $error("power down disturbed lead-off contents");

    chk_drive_hold: assert property ( // [R15]
        !(clk_en && wr_fire) |=> $stable(excitation))
        else $error("steering changed without a write");

endmodule

// [core/lofc_pkg.sv]
// package: lead-off control register map, field layouts and bus constants
package lofc_pkg;

    // ========================================================
    // register map (word index, byte address = index * 4)
    localparam int LOFC_IDX_W = 6;
    localparam logic [5:0] LOFC_IDX_GEN_CTRL = 6'h01;
    localparam logic [5:0] LOFC_IDX_LEAD_OFF = 6'h02;
    localparam logic [5:0] LOFC_IDX_STATUS = 6'h10;
    localparam int LOFC_ADDR_W = 8;
    localparam int LOFC_REG_W = 24;

    // ========================================================
    // reset values and masks
    localparam logic [23:0] LOFC_LEAD_OFF_RST = 24'h00_0000;
    localparam logic [23:0] LOFC_LEAD_OFF_RW = 24'hE7_919F;

    // general control bit positions
    localparam int LOFC_GEN_SOFTWARE_RESET_BIT = 0;
    localparam int LOFC_GEN_PWR = 1;
    localparam int LOFC_GEN_CAL = 2;

    // ========================================================
    // bus answers
    localparam logic [1:0] LOFC_RESP_OKAY = 2'h0;
    localparam logic [1:0] LOFC_RESP_SLVERR = 2'h2;

    // ========================================================
    // lead-off control layout, msb first
    typedef struct packed {
        logic left_arm_ac_phase;
        logic left_leg_ac_phase;
        logic right_arm_ac_phase;
        logic [1:0] rsv_20_19;
        logic common_electrode_ac_phase;
        logic left_arm_ac_enable;
        logic left_leg_ac_enable;
        logic right_arm_ac_enable;
        logic [1:0] rsv_14_13;
        logic common_electrode_ac_enable;
        logic [2:0] rsv_11_9;
        logic [1:0] ac_excitation_level;
        logic [1:0] rsv_6_5;
        logic [2:0] dc_excitation_level;
        logic global_ac_mode_select;
        logic detection_master_enable;
    } lofc_ctrl_t;

    // decoded excitation steering; vectors are [3]=la [2]=ll [1]=ra [0]=ce
    typedef struct packed {
        logic dc_detect_en;
        logic [2:0] dc_excitation_level;
        logic [3:0] ac_detect_en;
        logic [3:0] ac_phase;
        logic [1:0] ac_excitation_level;
    } lofc_drive_t;

    // write request handed from bus slave to register file
    typedef struct packed {
        logic [5:0] idx;
        logic [31:0] data;
        logic [3:0] strb;
    } lofc_wr_req_t;

endpackage

// [core/lofc_axil_slave.sv]
// file: axi4-lite slave handshake front end for the lead-off register bank
`timescale 1ns/1ps
module lofc_axil_slave
    import lofc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [LOFC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [LOFC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_fire,
    output lofc_wr_req_t wr_req,
    input wire logic wr_err,
    output logic [LOFC_IDX_W-1:0] rd_idx,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    // ========================================================
    // holding registers for address and data, taken in any order
    logic aw_full_q;
    logic w_full_q;
    logic [LOFC_IDX_W-1:0] aw_idx_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire b_done = clk_en & bvalid_q & s_axi_bready;
    wire r_done = clk_en & rvalid_q & s_axi_rready;

    // ready stays low while frozen so no beat is lost
    assign s_axi_awready = clk_en & ~aw_full_q;
    assign s_axi_wready = clk_en & ~w_full_q;
    assign s_axi_arready = clk_en & ~rvalid_q;
    // one write at a time: commit waits for the previous response
    assign wr_fire = clk_en & aw_full_q & w_full_q & ~bvalid_q;
    assign wr_req = '{idx: aw_idx_q, data: w_data_q, strb: w_strb_q};
    assign rd_idx = s_axi_araddr[LOFC_ADDR_W-1:2];

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // write channel capture and response
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_idx_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= LOFC_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[LOFC_ADDR_W-1:2];
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_err ? LOFC_RESP_SLVERR : LOFC_RESP_OKAY;
            end else if (b_done) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read answers one cycle after the address is taken
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= LOFC_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_data;
            rresp_q <= rd_err ? LOFC_RESP_SLVERR : LOFC_RESP_OKAY;
        end else if (r_done) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

// [core/lofc_decode.sv]
// file: combinational decode of lead-off control into excitation steering
`timescale 1ns/1ps
module lofc_decode
    import lofc_pkg::*;
(
    input lofc_ctrl_t ctrl,
    input wire logic cal_dac_on,
    output lofc_drive_t drive
);

    // ========================================================
    // gating terms
    wire master = ctrl.detection_master_enable; // [R02]
    wire global_ac = ctrl.global_ac_mode_select;
    // the cal dac shares the excitation path, so ac must stand down
    wire ac_allowed = master & ~cal_dac_on; // [R08]

    // per-electrode ac enables; common electrode ignores the global select
    assign drive.ac_detect_en[3] = ac_allowed & (global_ac | ctrl.left_arm_ac_enable); // [R06]
    assign drive.ac_detect_en[2] = ac_allowed & (global_ac | ctrl.left_leg_ac_enable); // [R06]
    assign drive.ac_detect_en[1] = ac_allowed & (global_ac | ctrl.right_arm_ac_enable); // [R06]
    assign drive.ac_detect_en[0] = ac_allowed & ctrl.common_electrode_ac_enable; // [R07]

    // dc path only in dc mode; select is a don't care for the detect enables when master is off
    assign drive.dc_detect_en = master & ~global_ac; // [R03] [R04] [R05]
    assign drive.dc_excitation_level = global_ac ? '0 : ctrl.dc_excitation_level; // [R11]

    // phases and ac level pass straight through
    assign drive.ac_phase = {ctrl.left_arm_ac_phase, ctrl.left_leg_ac_phase,
                             ctrl.right_arm_ac_phase, ctrl.common_electrode_ac_phase}; // [R09]
    assign drive.ac_excitation_level = ctrl.ac_excitation_level; // [R10]

endmodule

// [bench/testbench.sv]
// testbench: bus-level self-checking bench for the lead-off control register bank
`timescale 1ns/1ps
module testbench;
    import lofc_pkg::*;
    // ============================================================
    // design hookup and bench state
    logic clk_sys, arst_n, clk_en;
    logic [LOFC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    lofc_drive_t excitation;
    logic analog_power_enable, cal_dac_enable;
    int n_errors = 0;
    int n_checks = 0;
    logic [33:0] rq[$]; // expected {rresp, rdata}, oldest first
    logic [1:0] bq[$]; // expected bresp, oldest first
    logic [23:0] lo_m; // bench copy of lead_off_control
    logic pwr_m, cal_m;
    localparam logic [7:0] A_GEN = {LOFC_IDX_GEN_CTRL, 2'h0};
    localparam logic [7:0] A_LO = {LOFC_IDX_LEAD_OFF, 2'h0};
    localparam logic [7:0] A_ST = {LOFC_IDX_STATUS, 2'h0};
    localparam logic [7:0] A_UNM = 8'h0C;

    lofc_top u_lofc_top (.clk_sys, .arst_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .excitation, .analog_power_enable, .cal_dac_enable);

    // 100 MHz system clock
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ============================================================
    // expected steering, worked out bit by bit from the field layout
    function automatic logic [13:0] exp_drv(input logic [23:0] v, input logic cal);
        logic on;
        on = v[0] & ~cal;
        return {v[0] & ~v[1], v[1] ? 3'h0 : v[4:2], on & (v[1] | v[17]), on & (v[1] | v[16]),
                on & (v[1] | v[15]), on & v[12], v[23:21], v[18], v[8:7]};
    endfunction

    // ============================================================
    // comparisons and the closing report
    task automatic chk_rd(input logic [33:0] e, input logic [33:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error read expected %h seen %h", e, g);
        end
    endtask

    task automatic chk_sig(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic hang(input string nm);
        n_errors++;
        $display("Error %s expected answer seen none", nm);
        end_of_test();
    endtask

    // result watcher: each answer taken is held against the oldest note
    always @(posedge clk_sys) begin
        if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
            chk_rd(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) begin
            chk_sig("bresp", {14'h0, bq.pop_front()}, {14'h0, s_axi_bresp});
        end
    end

    // ============================================================
    // bus master: request held until its own ready is sampled high
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        bit aw_ok, w_ok, b_ok;
        aw_ok = 0;
        w_ok = 0;
        b_ok = 0;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int i = 0; i < 50 && !b_ok; i++) begin
            @(posedge clk_sys);
            if (aw_ok && w_ok && s_axi_bvalid) begin
                b_ok = 1;
                s_axi_bready <= 1'h0;
            end
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1;
                s_axi_wvalid <= 1'h0;
            end
        end
        if (!b_ok) hang("write");
        else @(posedge clk_sys); // one edge between requests, so bready is never set twice in a step
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        bit ar_ok, r_ok;
        ar_ok = 0;
        r_ok = 0;
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int i = 0; i < 50 && !r_ok; i++) begin
            @(posedge clk_sys);
            if (ar_ok && s_axi_rvalid) begin
                r_ok = 1;
                s_axi_rready <= 1'h0;
            end
            if (!ar_ok && s_axi_arready) begin
                ar_ok = 1;
                s_axi_arvalid <= 1'h0;
            end
        end
        if (!r_ok) hang("read");
        else @(posedge clk_sys); // one edge between requests, so rready is never set twice in a step
    endtask

    // register-level helpers that keep the bench copy in step
    task automatic wr_lo(input logic [31:0] d, input logic [3:0] s);
        for (int k = 0; k < 3; k++) begin
            if (s[k]) lo_m[8*k +: 8] = d[8*k +: 8];
        end
        lo_m = lo_m & LOFC_LEAD_OFF_RW; // reserved bits never stored
        wr(A_LO, d, s, LOFC_RESP_OKAY);
    endtask

    task automatic wr_gen(input logic [2:0] d);
        if (d[LOFC_GEN_SOFTWARE_RESET_BIT]) begin
            lo_m = 24'h00_0000;
            pwr_m = 1'h0;
            cal_m = 1'h0;
        end else begin
            pwr_m = d[LOFC_GEN_PWR];
            cal_m = d[LOFC_GEN_CAL];
        end
        wr(A_GEN, {29'h0, d}, 4'hF, LOFC_RESP_OKAY);
    endtask

    // readback of every mapped word plus the steering pins
    task automatic chk_all();
        rd(A_LO, {LOFC_RESP_OKAY, 8'h00, lo_m});
        rd(A_GEN, {LOFC_RESP_OKAY, 29'h0, cal_m, pwr_m, 1'h0});
        rd(A_ST, {LOFC_RESP_OKAY, 17'h0, pwr_m, exp_drv(lo_m, cal_m)});
        chk_sig("excitation", {2'h0, exp_drv(lo_m, cal_m)}, {2'h0, excitation});
        chk_sig("power", {15'h0, pwr_m}, {15'h0, analog_power_enable});
        chk_sig("cal", {15'h0, cal_m}, {15'h0, cal_dac_enable});
    endtask

    // ============================================================
    // main sequence
    initial begin
        void'($urandom(98));
        {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0_0000_0000_0000;
        clk_en = 1'h1;
        {lo_m, pwr_m, cal_m} = 26'h000_0000;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'h1;
        chk_all(); // reset value all zero
        // every enable/select/cal mix, random fields, random lanes later on
        // k=0 to k=1 flips the select while master stays off
        for (int k = 0; k < 40; k++) begin
            wr_gen({1'(k >> 2), 1'($urandom), 1'h0});
            wr_lo(($urandom & 32'h00E7_919C) | 32'({k[0], k[1]}), (k < 8) ? 4'hF : 4'($urandom)); // zero reserved
            chk_all();
        end
        // power-down keeps the register
        wr_gen(3'h2);
        wr_lo(32'h00A7_919F, 4'hF);
        wr_gen(3'h0);
        chk_all(); // contents survive power-down
        // refused accesses leave state alone
        wr(A_UNM, 32'hFFFF_FFFF, 4'hF, LOFC_RESP_SLVERR); // unmapped write
        wr(A_ST, 32'hFFFF_FFFF, 4'hF, LOFC_RESP_SLVERR); // status is read only
        rd(A_UNM, {LOFC_RESP_SLVERR, 32'h0000_0000}); // unmapped read
        chk_all(); // nothing moved
        // clock enable low must hold every ready low
        clk_en <= 1'h0;
        repeat (2) @(posedge clk_sys);
        chk_sig("ready", 16'h0000, {13'h0, s_axi_awready, s_axi_wready, s_axi_arready});
        clk_en <= 1'h1;
        // software reset clears lead-off, power and cal
        wr_gen(3'h6);
        wr_lo(32'h00E7_919F, 4'hF);
        wr_gen(3'h1);
        chk_all(); // back to reset value
        // second hardware reset in mid-run
        wr_lo(32'h0002_1183, 4'hF);
        @(posedge clk_sys);
        arst_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'h1;
        {lo_m, pwr_m, cal_m} = 26'h000_0000;
        chk_all(); // reset value after async reset
        repeat (3) @(posedge clk_sys);
        end_of_test();
    end
endmodule
